// ==== include/ged_pkg.sv ====
// Purpose: Constants and types for the GPIO edge detect and pin interrupt block.
// Assumes: APB slave with 32-bit data; each register sits in one aligned word at four times its index.
// Notes: Port 0 occupies bits 7:0 and port 1 bits 15:8 of every 16-bit pin vector.
package ged_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int DATA_W = 32;           // APB data width.
    localparam int ADDR_W = 18;           // Enough for four times the highest index.
    localparam int PORT_W = 8;            // Pins per port.
    localparam int NPORT = 2;             // Number of ports.
    localparam int PIN_W = PORT_W * NPORT;// All pins together.
    localparam int SYNC_STAGES = 2;       // Flip-flops in each pin synchroniser.

    // ==========================================================
    // Register indices and byte addresses
    // ==========================================================
    localparam logic [15:0] IDX_P0_RISE = 16'hA028;
    localparam logic [15:0] IDX_P1_RISE = 16'hA029;
    localparam logic [15:0] IDX_IRQ_EN = 16'hA02A;
    localparam logic [15:0] IDX_P0_FALL = 16'hA038;
    localparam logic [15:0] IDX_P1_FALL = 16'hA039;
    localparam logic [ADDR_W-1:0] ADDR_P0_RISE = {IDX_P0_RISE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_P1_RISE = {IDX_P1_RISE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = {IDX_IRQ_EN, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_P0_FALL = {IDX_P0_FALL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_P1_FALL = {IDX_P1_FALL, 2'h0};

    // ==========================================================
    // Reset values and field positions
    // ==========================================================
    localparam logic [PIN_W-1:0] PIN_RST = 16'h0000;   // Enables and flags after reset.
    localparam logic [NPORT-1:0] IRQEN_RST = 2'h0;     // Port interrupt enables after reset.
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam int P0_LSB = 0;            // Port 0 slice base.
    localparam int P1_LSB = 8;            // Port 1 slice base.

    // Decoded register selection.
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_P0_RISE,
        SEL_P1_RISE,
        SEL_P0_FALL,
        SEL_P1_FALL,
        SEL_IRQ_EN
    } ged_sel_t;

endpackage

// ==== rtl/ged_sync.sv ====
// Purpose: Two-stage synchroniser for the sixteen port pins.
// Assumes: Pins are asynchronous to sys_clk.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps

module ged_sync
(
    sys_clk,
    sys_rst,
    clkEn,
    pinsIn,
    pinsSync
);
    input wire logic sys_clk;
    input wire logic sys_rst;
    input wire logic clkEn;
    input wire logic [ged_pkg::PIN_W-1:0] pinsIn;
    output logic [ged_pkg::PIN_W-1:0] pinsSync;

    // Both stages held as one state word.
    typedef struct packed
    {
        logic [ged_pkg::PIN_W-1:0] meta;  // First stage, may be metastable.
        logic [ged_pkg::PIN_W-1:0] stable;// Second stage, safe to read.
    } ged_sync_t;

    ged_sync_t st_r;   // Registered state.
    ged_sync_t st_nxt; // Next state.

    // ==========================================================
    // Next state
    // ==========================================================
    // Each pin passes two flops before anything looks at it.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.meta = pinsIn;
        st_nxt.stable = st_r.meta;
    end

    // Clock enable freezes the chain, so a slow pin is simply sampled later.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else if (clkEn)
        begin
            st_r <= st_nxt;
        end
    end

    assign pinsSync = st_r.stable;

    // Two enabled edges bring a pin value to the output.
    chk_sync_delay: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clkEn ##1 clkEn) |=> (pinsSync == $past(pinsIn, 2)))
        else $error("Synchronised pins do not follow the inputs after two edges.");

endmodule

// ==== rtl/ged_top.sv ====
// Purpose: Edge detection and pin interrupt for GPIO ports 0 and 1, with an APB register slave.
// Assumes: Zero-wait APB while clkEn is high; pin inputs asynchronous to sys_clk; clkEn low freezes all state.
// Notes: Read data is captured in the setup cycle, so a read shows the flags as they stood then.
`timescale 1ns/1ps

module ged_top
(
    sys_clk,
    sys_rst,
    clkEn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    pstrb,
    prdata,
    pready,
    pslverr,
    port0Pins,
    port1Pins,
    port0Irq,
    port1Irq,
    wakeEvent
);
    input wire logic sys_clk;
    input wire logic sys_rst;
    input wire logic clkEn;
    input wire logic psel;
    input wire logic penable;
    input wire logic pwrite;
    input wire logic [ged_pkg::ADDR_W-1:0] paddr;
    input wire logic [ged_pkg::DATA_W-1:0] pwdata;
    input wire logic [3:0] pstrb;
    output logic [ged_pkg::DATA_W-1:0] prdata;
    output logic pready;
    output logic pslverr;
    input wire logic [ged_pkg::PORT_W-1:0] port0Pins;
    input wire logic [ged_pkg::PORT_W-1:0] port1Pins;
    output logic port0Irq;
    output logic port1Irq;
    output logic wakeEvent;

    // ==========================================================
    // State
    // ==========================================================
    // Every flop of the block outside the synchroniser lives in this one word.
    typedef struct packed
    {
        logic [ged_pkg::PIN_W-1:0] riseEn;   // Rising detection enables, both ports.
        logic [ged_pkg::PIN_W-1:0] fallEn;   // Falling detection enables, both ports.
        logic [ged_pkg::PIN_W-1:0] riseFlag; // Sticky rising flags.
        logic [ged_pkg::PIN_W-1:0] fallFlag; // Sticky falling flags.
        logic [ged_pkg::NPORT-1:0] irqEn;    // Per-port pin interrupt enables.
        logic [ged_pkg::PIN_W-1:0] pinPrev;  // Previous synchronised sample.
        logic [ged_pkg::DATA_W-1:0] rdData;  // Read data captured at setup.
        logic rdErr;                         // Error captured at setup.
        logic rdValid;                       // Read data captured for the transfer under way.
        logic [ged_pkg::NPORT-1:0] irqOut;   // Registered port interrupts.
        logic wake;                          // Registered wake-up pulse.
    } ged_state_t;

    ged_state_t st_r;   // Registered state.
    ged_state_t st_nxt; // Next state.

    logic [ged_pkg::PIN_W-1:0] pinsSync; // Synchronised pins.
    logic [ged_pkg::PIN_W-1:0] riseEv;   // Enabled rising edges this cycle.
    logic [ged_pkg::PIN_W-1:0] fallEv;   // Enabled falling edges this cycle.
    logic [ged_pkg::NPORT-1:0] portAny;  // Any flag set, per port.
    ged_pkg::ged_sel_t regSel;           // Decoded register.
    logic setupPh;                       // Read capture due: setup, or access after a frozen setup edge.
    logic accessPh;                      // APB access cycle.
    logic wrStrobe;                      // Write takes effect on this edge.

    // ==========================================================
    // Functions
    // ==========================================================
    // Address decode, used for both read capture and write.
    function automatic ged_pkg::ged_sel_t decode_addr(input logic [ged_pkg::ADDR_W-1:0] a);
        ged_pkg::ged_sel_t s;
        s = ged_pkg::SEL_NONE;
        if (a == ged_pkg::ADDR_P0_RISE)
        begin
            s = ged_pkg::SEL_P0_RISE;
        end
        else if (a == ged_pkg::ADDR_P1_RISE)
        begin
            s = ged_pkg::SEL_P1_RISE;
        end
        else if (a == ged_pkg::ADDR_P0_FALL)
        begin
            s = ged_pkg::SEL_P0_FALL;
        end
        else if (a == ged_pkg::ADDR_P1_FALL)
        begin
            s = ged_pkg::SEL_P1_FALL;
        end
        else if (a == ged_pkg::ADDR_IRQ_EN)
        begin
            s = ged_pkg::SEL_IRQ_EN;
        end
        return s;
    endfunction

    // Mask of the bits cleared by a write of zero to one port slice.
    // Bits written one leave their flag alone; other ports are untouched.
    function automatic logic [ged_pkg::PIN_W-1:0] clear_mask(input logic hit, input int base,
        input logic [ged_pkg::PORT_W-1:0] wd);
        logic [ged_pkg::PIN_W-1:0] m;
        m = '0;
        if (hit)
        begin
            m[base +: ged_pkg::PORT_W] = ~wd;
        end
        return m;
    endfunction

    // ==========================================================
    // Pin synchroniser
    // ==========================================================
    // Pins are asynchronous, so they are re-timed before edge detection.
    ged_sync u_sync
    (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .pinsIn({port1Pins, port0Pins}),
        .pinsSync(pinsSync)
    );

    // ==========================================================
    // Edge detection
    // ==========================================================
    // Each port has its own rising and falling detectors and flags.
    genvar gp;
    generate
        for (gp = 0; gp < ged_pkg::NPORT; gp++)
        begin : g_port
            localparam int LSB = gp * ged_pkg::PORT_W;
            // Compare current and previous sample, gated by the enables.
            assign riseEv[LSB +: ged_pkg::PORT_W] = pinsSync[LSB +: ged_pkg::PORT_W]
                & ~st_r.pinPrev[LSB +: ged_pkg::PORT_W] & st_r.riseEn[LSB +: ged_pkg::PORT_W];
            assign fallEv[LSB +: ged_pkg::PORT_W] = ~pinsSync[LSB +: ged_pkg::PORT_W]
                & st_r.pinPrev[LSB +: ged_pkg::PORT_W] & st_r.fallEn[LSB +: ged_pkg::PORT_W];
            // Either kind of flag on the port counts toward its interrupt.
            assign portAny[gp] = |(st_r.riseFlag[LSB +: ged_pkg::PORT_W] | st_r.fallFlag[LSB +: ged_pkg::PORT_W]);
        end
    endgenerate

    // ==========================================================
    // APB phase decode
    // ==========================================================
    // No wait states while clkEn is high. A frozen clock holds pready low so no write is lost, and if it
    // froze the setup edge, pready also waits one enabled edge so that the read data is captured fresh.
    assign regSel = decode_addr(paddr);
    assign setupPh = psel & ~st_r.rdValid;
    assign accessPh = psel & penable;
    assign pready = accessPh & clkEn & st_r.rdValid;
    // A write lands only at the edge that completes the transfer.
    assign wrStrobe = pready & pwrite & pstrb[0];

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb
    begin
        logic [ged_pkg::PIN_W-1:0] riseClr;
        logic [ged_pkg::PIN_W-1:0] fallClr;
        riseClr = '0;
        fallClr = '0;
        st_nxt = st_r;

        // Keep the last sample for the next comparison.
        st_nxt.pinPrev = pinsSync;

        // Register writes load enables; a zero bit in a rising or falling enable also requests a flag clear.
        if (wrStrobe)
        begin
            unique case (regSel)
                ged_pkg::SEL_P0_RISE:
                begin
                    st_nxt.riseEn[ged_pkg::P0_LSB +: ged_pkg::PORT_W] = pwdata[ged_pkg::PORT_W-1:0];
                end
                ged_pkg::SEL_P1_RISE:
                begin
                    st_nxt.riseEn[ged_pkg::P1_LSB +: ged_pkg::PORT_W] = pwdata[ged_pkg::PORT_W-1:0];
                end
                ged_pkg::SEL_P0_FALL:
                begin
                    st_nxt.fallEn[ged_pkg::P0_LSB +: ged_pkg::PORT_W] = pwdata[ged_pkg::PORT_W-1:0];
                end
                ged_pkg::SEL_P1_FALL:
                begin
                    st_nxt.fallEn[ged_pkg::P1_LSB +: ged_pkg::PORT_W] = pwdata[ged_pkg::PORT_W-1:0];
                end
                ged_pkg::SEL_IRQ_EN:
                begin
                    st_nxt.irqEn = pwdata[ged_pkg::NPORT-1:0];
                end
                ged_pkg::SEL_NONE:
                begin
                    // Unmapped writes change nothing.
                    st_nxt.irqEn = st_r.irqEn;
                end
            endcase
            // Zero in a rising enable bit clears that rising flag.
            riseClr = clear_mask(regSel == ged_pkg::SEL_P0_RISE, ged_pkg::P0_LSB, pwdata[ged_pkg::PORT_W-1:0])
                | clear_mask(regSel == ged_pkg::SEL_P1_RISE, ged_pkg::P1_LSB, pwdata[ged_pkg::PORT_W-1:0]);
            // Zero in a falling enable bit clears that falling flag.
            fallClr = clear_mask(regSel == ged_pkg::SEL_P0_FALL, ged_pkg::P0_LSB, pwdata[ged_pkg::PORT_W-1:0])
                | clear_mask(regSel == ged_pkg::SEL_P1_FALL, ged_pkg::P1_LSB, pwdata[ged_pkg::PORT_W-1:0]);
        end

        // Flags stick until cleared; a new edge in the clearing cycle wins.
        st_nxt.riseFlag = (st_r.riseFlag & ~riseClr) | riseEv;
        st_nxt.fallFlag = (st_r.fallFlag & ~fallClr) | fallEv;

        // Port interrupt is the OR of its flags, gated by its enable.
        st_nxt.irqOut = portAny & st_r.irqEn;

        // Any enabled edge also wakes the CPU in the same step.
        st_nxt.wake = |(riseEv | fallEv);

        // Marks the capture as done until the transfer completes; idle clears it.
        st_nxt.rdValid = psel & ~pready;

        // Read data is sampled in setup so prdata comes straight from a flop in access.
        if (setupPh)
        begin
            st_nxt.rdData = ged_pkg::DATA_ZERO;
            st_nxt.rdErr = 1'b0;
            unique case (regSel)
                ged_pkg::SEL_P0_RISE:
                begin
                    st_nxt.rdData[ged_pkg::PORT_W-1:0] = st_r.riseFlag[ged_pkg::P0_LSB +: ged_pkg::PORT_W];
                end
                ged_pkg::SEL_P1_RISE:
                begin
                    st_nxt.rdData[ged_pkg::PORT_W-1:0] = st_r.riseFlag[ged_pkg::P1_LSB +: ged_pkg::PORT_W];
                end
                ged_pkg::SEL_P0_FALL:
                begin
                    st_nxt.rdData[ged_pkg::PORT_W-1:0] = st_r.fallFlag[ged_pkg::P0_LSB +: ged_pkg::PORT_W];
                end
                ged_pkg::SEL_P1_FALL:
                begin
                    st_nxt.rdData[ged_pkg::PORT_W-1:0] = st_r.fallFlag[ged_pkg::P1_LSB +: ged_pkg::PORT_W];
                end
                ged_pkg::SEL_IRQ_EN:
                begin
                    st_nxt.rdData[ged_pkg::NPORT-1:0] = st_r.irqEn;
                end
                ged_pkg::SEL_NONE:
                begin
                    // Unmapped address reads zero and reports an error.
                    st_nxt.rdErr = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Everything clears to zero, so enables are off and flags clear.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else if (clkEn)
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Read data and error are held only during the access phase to keep the bus quiet otherwise.
    assign prdata = accessPh ? st_r.rdData : ged_pkg::DATA_ZERO;
    assign pslverr = accessPh & st_r.rdErr;
    assign port0Irq = st_r.irqOut[0];
    assign port1Irq = st_r.irqOut[1];
    assign wakeEvent = st_r.wake;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_rise_sets_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clkEn && riseEv != '0) |=> ((st_r.riseFlag & $past(riseEv)) == $past(riseEv)))
        else $error("Enabled rising edge did not set its flag.");

    chk_fall_sets_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clkEn && fallEv != '0) |=> ((st_r.fallFlag & $past(fallEv)) == $past(fallEv)))
        else $error("Enabled falling edge did not set its flag.");

    chk_rise_needs_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> ((st_r.riseFlag & ~$past(st_r.riseFlag) & ~$past(st_r.riseEn)) == '0))
        else $error("Rising flag set on a pin with detection off.");

    chk_fall_needs_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> ((st_r.fallFlag & ~$past(st_r.fallFlag) & ~$past(st_r.fallEn)) == '0))
        else $error("Falling flag set on a pin with detection off.");

    chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(pready && pwrite) |=> ((st_r.riseFlag & $past(st_r.riseFlag)) == $past(st_r.riseFlag)))
        else $error("Rising flag dropped without a clearing write.");

    chk_rise_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pready && wrStrobe && regSel == ged_pkg::SEL_P0_RISE)
        |=> ((st_r.riseFlag[7:0] & ~$past(pwdata[7:0]) & ~$past(riseEv[7:0])) == 8'h00))
        else $error("Writing zero to a rising enable left its flag set.");

    chk_fall_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pready && wrStrobe && regSel == ged_pkg::SEL_P1_FALL)
        |=> ((st_r.fallFlag[15:8] & ~$past(pwdata[7:0]) & ~$past(fallEv[15:8])) == 8'h00))
        else $error("Writing zero to a falling enable left its flag set.");

    chk_irq_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clkEn |=> (port0Irq == ($past(portAny[0]) && $past(st_r.irqEn[0]))))
        else $error("Port 0 interrupt does not follow its flags and enable.");

    chk_irq1_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clkEn |=> (port1Irq == ($past(portAny[1]) && $past(st_r.irqEn[1]))))
        else $error("Port 1 interrupt does not follow its flags and enable.");

    chk_wake_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clkEn && (riseEv | fallEv) != '0) |=> wakeEvent)
        else $error("Enabled edge did not raise the wake-up pulse.");

    chk_reset_zero: assert property (@(posedge sys_clk)
        $fell(sys_rst) |-> (st_r.riseEn == '0 && st_r.fallEn == '0 && st_r.riseFlag == '0 && st_r.fallFlag == '0))
        else $error("Edge registers not zero after reset.");

endmodule

// ==== tb/ged_pin_model.sv ====
// Purpose: Model of the external circuitry that drives the sixteen port pins.
// Assumes: The bench asks for pin levels; the model applies them on the system clock.
// Notes: Levels change only after a rising edge, so each level stands for at least one full cycle.
`timescale 1ns/1ps

module ged_pin_model
(
    sys_clk,
    pinLevel,
    port0Pins,
    port1Pins
);
    input wire logic sys_clk;
    input wire logic [ged_pkg::PIN_W-1:0] pinLevel;
    output logic [ged_pkg::PORT_W-1:0] port0Pins;
    output logic [ged_pkg::PORT_W-1:0] port1Pins;

    // ==========================================================
    // Pin drivers
    // ==========================================================
    // Current level on every pin; pins idle low until the bench asks otherwise.
    logic [ged_pkg::PIN_W-1:0] pinsNow_r = 16'h0000;

    // A real source may glitch for less than a clock, which the device may miss, so
    // this model never emits a pulse shorter than one cycle.
    always @(posedge sys_clk)
    begin
        pinsNow_r <= pinLevel;
    end

    // Port 0 is the low byte, port 1 the high byte.
    assign port0Pins = pinsNow_r[ged_pkg::P0_LSB +: ged_pkg::PORT_W];
    assign port1Pins = pinsNow_r[ged_pkg::P1_LSB +: ged_pkg::PORT_W];
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the GPIO edge detect and pin interrupt block.
// Assumes: Zero-wait APB slave while clkEn is high; pins driven through the pin model.
// Notes: The four edge registers are exercised by one loop over a table of addresses.
`timescale 1ns/1ps

module testbench;
    // ==========================================================
    // Signals
    // ==========================================================
    logic sys_clk = 1'b0; // 50 ns period.
    logic sys_rst = 1'b1; // Held for eight cycles at start.
    logic clkEn = 1'b1; // Dropped only by the freeze tests.
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ged_pkg::ADDR_W-1:0] paddr = 18'h00000;
    logic [ged_pkg::DATA_W-1:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF; // All byte lanes written.
    logic [ged_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic port0Irq;
    logic port1Irq;
    logic wakeEvent;
    logic [ged_pkg::PORT_W-1:0] port0Pins;
    logic [ged_pkg::PORT_W-1:0] port1Pins;
    logic [ged_pkg::PIN_W-1:0] pinLevel = 16'h0000; // Levels asked of the pin model.
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0; // Cycle count for the hang guard.
    int wakes = 0; // Wake pulses seen so far.
    // Order: port 0 rise, port 1 rise, port 0 fall, port 1 fall; entry i^2 is the other direction.
    logic [ged_pkg::ADDR_W-1:0] regAddr [4] = '{ged_pkg::ADDR_P0_RISE, ged_pkg::ADDR_P1_RISE,
        ged_pkg::ADDR_P0_FALL, ged_pkg::ADDR_P1_FALL};

    initial forever #25 sys_clk = ~sys_clk;

    ged_top u_ged_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port0Pins(port0Pins), .port1Pins(port1Pins), .port0Irq(port0Irq),
        .port1Irq(port1Irq), .wakeEvent(wakeEvent));

    ged_pin_model u_ged_pin_model (.sys_clk(sys_clk), .pinLevel(pinLevel), .port0Pins(port0Pins),
        .port1Pins(port1Pins));

    // ==========================================================
    // Reporting
    // ==========================================================
    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Compares with case equality so an unknown never passes.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Counts wake pulses and cuts a hang short; the whole test needs well under 1000 cycles.
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (wakeEvent === 1'b1)
            wakes <= wakes + 1;
        if (cycles == 4000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    // ==========================================================
    // APB master
    // ==========================================================
    // One transfer: setup, then access held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [17:0] addr, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // Waits as long as the slave asks; only the bench timeout ends a hang.
        while (pready !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads one register and compares both the data and the error response.
    task automatic rdchk(input string what, input logic [17:0] addr, input logic [31:0] exp, input logic expErr);
        logic [31:0] d;
        logic e;
        apb(1'b0, addr, 32'h0000_0000, d, e);
        check(what, exp, d);
        check("pslverr", {31'h0, expErr}, {31'h0, e});
    endtask

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial
    begin
        logic [31:0] d;
        logic e;
        logic [7:0] lvl;
        int w0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) rdchk("reset value", regAddr[i], 32'h0000_0000, 1'b0);
        rdchk("irq enable reset", ged_pkg::ADDR_IRQ_EN, 32'h0000_0000, 1'b0);
        rdchk("unmapped read", 18'h00000, 32'h0000_0000, 1'b1);
        // Each pass: park the port at the idle level, enable half the pins, flip all of them.
        for (int i = 0; i < 4; i++)
        begin
            lvl = (i >= 2) ? 8'hFF : 8'h00;
            pinLevel <= {8'h00, lvl} << (8 * (i % 2));
            repeat (6) @(posedge sys_clk);
            w0 = wakes;
            apb(1'b1, regAddr[i], 32'h0000_005A, d, e);
            pinLevel <= {8'h00, ~lvl} << (8 * (i % 2));
            repeat (6) @(posedge sys_clk);
            // Only enabled pins latch, and the flags outlive the edge.
            rdchk("edge flags", regAddr[i], 32'h0000_005A, 1'b0);
            rdchk("other direction flags", regAddr[i ^ 2], 32'h0000_0000, 1'b0);
            check("wake pulse", 32'h0000_0001, {31'h0, wakes > w0});
            check("irq while masked", 32'h0000_0000, {30'h0, port1Irq, port0Irq});
            apb(1'b1, ged_pkg::ADDR_IRQ_EN, 32'h0000_0001 << (i % 2), d, e);
            repeat (4) @(posedge sys_clk);
            check("irq raised", 32'h0000_0001 << (i % 2), {30'h0, port1Irq, port0Irq});
            apb(1'b1, regAddr[i], 32'h0000_0000, d, e);
            repeat (4) @(posedge sys_clk);
            check("irq after clear", 32'h0000_0000, {30'h0, port1Irq, port0Irq});
            rdchk("flags after clear", regAddr[i], 32'h0000_0000, 1'b0);
            apb(1'b1, ged_pkg::ADDR_IRQ_EN, 32'h0000_0000, d, e);
        end
        // Frozen clock: the pin edge waits and raises no wake, then lands once the clock runs again.
        apb(1'b1, ged_pkg::ADDR_P0_RISE, 32'h0000_0001, d, e);
        w0 = wakes;
        clkEn <= 1'b0;
        pinLevel <= 16'h0001;
        repeat (6) @(posedge sys_clk);
        check("wake while frozen", 32'h0000_0000, {31'h0, wakes > w0});
        clkEn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        // The setup edge of this read is frozen, so the slave must capture the flag before it answers.
        fork
            rdchk("flag across freeze", ged_pkg::ADDR_P0_RISE, 32'h0000_0001, 1'b0);
            begin
                clkEn <= 1'b0;
                repeat (3) @(posedge sys_clk);
                clkEn <= 1'b1;
            end
        join
        // A write without byte lane 0 is ignored, so the flag survives a zero.
        pstrb <= 4'hE;
        apb(1'b1, ged_pkg::ADDR_P0_RISE, 32'h0000_0000, d, e);
        pstrb <= 4'hF;
        rdchk("flag after masked write", ged_pkg::ADDR_P0_RISE, 32'h0000_0001, 1'b0);
        end_of_test();
    end
endmodule
